// ==== hdl/serial_pkg.sv ====
// Package: register map, field positions and reset values of the serial transceiver
package serial_pkg;
  // Register indices as printed, byte address is four times the index
  localparam logic [7:0] DATA_IDX = 8'h0c;
  localparam logic [7:0] STATUS_IDX = 8'h0b;
  localparam logic [7:0] CONTROL_IDX = 8'h0a;
  localparam logic [7:0] DIVISOR_IDX = 8'h09;
  localparam logic [7:0] IRQ_ACK_IDX = 8'h08;
  // Status field positions
  localparam int ST_RXC = 7;
  localparam int ST_TXC = 6;
  localparam int ST_EMPTY = 5;
  localparam int ST_FE = 4;
  localparam int ST_OVR = 3;
  // Control field positions
  localparam int CT_RXIE = 7;
  localparam int CT_TXIE = 6;
  localparam int CT_EMIE = 5;
  localparam int CT_RECEIVER_ENABLE = 4;
  localparam int CT_TRANSMITTER_ENABLE = 3;
  localparam int CT_NINE = 2;
  localparam int CT_RX8 = 1;
  localparam int CT_TX8 = 0;
  localparam logic [7:0] CONTROL_RST = 8'h02;
  localparam logic [7:0] STATUS_RST = 8'h20;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  // Oversampling and vote points
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;

  typedef struct packed {
    logic rx_complete;
    logic tx_complete;
    logic tx_empty;
  } irq_s;
endpackage

// ==== hdl/serial_uart.sv ====
// Serial transceiver: APB registers, baud divider, transmitter and receiver
`timescale 1ns/10ps
// Operation
// RQ1 - Set receive complete on every transfer
// RQ2 - Data read clears it; request follows flag
// RQ3 - Transmit complete after stop, nothing pending
// RQ4 - Vector acknowledge or write-one clears
// RQ5 - Empty set on load, cleared by write
// RQ6 - Empty flag reads one after reset
// RQ7 - Empty request while flag and enable
// RQ8 - Framing flag follows sampled stop bit
// RQ9 - Overrun detected, shown after older read
// RQ10 - Overrun cleared on successful transfer
// RQ11 - Low three status bits read zero
// RQ12 - Transmit complete request when enabled
// RQ13 - Receiver off blocks flag setting only
// RQ14 - Transmitter drains before it stops
// RQ15 - Nine bit characters use ninth fields
// RQ16 - Control bit1 ninth received, bit0 write-only
// RQ17 - Baud is clock over sixteen times divisor+1
// RQ18 - Software keeps divisor error within one percent
// RQ19 - Sixteen samples, vote on 8,9,10
// RQ20 - Start zero, LSB first, stop one
// RQ21 - Data address splits into two registers
// RQ22 - Three separate gated request levels
// RQ23 - Status readable, only transmit complete writable
module serial_uart
  import serial_pkg::*;
(
  input wire logic clk_sys_i, // System clock
  input wire logic srst_i, // Synchronous reset
  input wire logic psel_i, // APB select
  input wire logic penable_i, // APB enable
  input wire logic pwrite_i, // APB direction
  input wire logic [31:0] paddr_i, // APB address
  input wire logic [31:0] pwdata_i, // APB write data
  output logic [31:0] prdata_o, // APB read data
  output logic pready_o, // APB ready
  output logic pslverr_o, // APB error
  input wire logic global_irq_en_i, // Global interrupt enable
  input wire logic tx_vector_ack_i, // Transmit complete vector taken
  output irq_s irq_o, // Interrupt requests
  input wire logic rxd_i, // Serial receive line
  output logic txd_o // Serial transmit line
);

  logic [7:0] control_q;
  logic [7:0] divisor_q;
  logic rxc_q, txc_q, empty_q, fe_q, ovr_q, ovr_pend_q, fe_pend_q;
  logic [7:0] rx_data_q, tx_data_q;
  logic tx_ninth_q;
  logic [2:0] rxd_sync_q;
  logic rxd_q;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    return a == {22'h0, idx, 2'b00};
  endfunction

  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i;
  wire rd = access & ~pwrite_i;
  wire data_wr = wr & hit(paddr_i, DATA_IDX); // RQ21
  wire data_rd = rd & hit(paddr_i, DATA_IDX); // RQ21
  wire mapped = hit(paddr_i, DATA_IDX) | hit(paddr_i, STATUS_IDX) | hit(paddr_i, CONTROL_IDX) |
                hit(paddr_i, DIVISOR_IDX) | hit(paddr_i, IRQ_ACK_IDX);

  // Baud: 16x tick every divisor+1 cycles
  logic [7:0] div_cnt_q;
  logic tick16;
  assign tick16 = div_cnt_q == divisor_q; // RQ17
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || tick16) begin
      div_cnt_q <= 8'h00;
    end else begin
      div_cnt_q <= div_cnt_q + 8'h01;
    end
  end
  logic [3:0] tx_phase_q;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_phase_q <= 4'h0;
    end else if (tick16) begin
      tx_phase_q <= tx_phase_q + 4'h1;
    end
  end
  wire baud_tick = tick16 && tx_phase_q == OVERSAMPLE_LAST; // RQ17

  // Input synchroniser, change counts once second and third agree
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rxd_sync_q <= 3'b111;
      rxd_q <= 1'b1;
    end else begin
      rxd_sync_q <= {rxd_sync_q[1:0], rxd_i};
      if (rxd_sync_q[1] == rxd_sync_q[2]) begin
        rxd_q <= rxd_sync_q[2];
      end
    end
  end

  // Transmitter
  typedef enum {TX_IDLE, TX_LOADED, TX_SHIFT} tx_state_e;
  tx_state_e tx_state_q;
  logic [10:0] tx_shift_q;
  logic [3:0] tx_left_q;
  logic tx_pending_q;
  wire tx_nine = control_q[CT_NINE];
  wire tx_load = tx_pending_q && (tx_state_q == TX_IDLE ||
                 (tx_state_q == TX_SHIFT && baud_tick && tx_left_q == 4'h1));
  wire tx_done = tx_state_q == TX_SHIFT && baud_tick && tx_left_q == 4'h1 && !tx_pending_q; // RQ3
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_state_q <= TX_IDLE;
      tx_shift_q <= 11'h7ff;
      tx_left_q <= 4'h0;
      txd_o <= 1'b1;
    end else if (tx_load) begin
      tx_state_q <= TX_LOADED;
      // RQ15 RQ20
      tx_shift_q <= tx_nine ? {1'b1, tx_ninth_q, tx_data_q, 1'b0} : {2'b11, tx_data_q, 1'b0};
      // Extra count keeps the stop bit on the line a full bit time
      tx_left_q <= tx_nine ? 4'hc : 4'hb;
    end else if (baud_tick) begin
      unique case (tx_state_q)
        TX_IDLE: txd_o <= 1'b1;
        TX_LOADED, TX_SHIFT: begin
          // RQ20 LSB first after start bit; stop bit stays one bit time
          txd_o <= tx_shift_q[0];
          tx_shift_q <= {1'b1, tx_shift_q[10:1]};
          tx_left_q <= tx_left_q - 4'h1;
          tx_state_q <= (tx_state_q == TX_SHIFT && tx_left_q == 4'h1) ? TX_IDLE : TX_SHIFT;
        end
      endcase
    end
  end
  // Pending data is sent even if the enable drops mid-stream
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tx_pending_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_ninth_q <= 1'b0;
    end else if (data_wr && (control_q[CT_TRANSMITTER_ENABLE] || tx_state_q != TX_IDLE)) begin // RQ14
      tx_pending_q <= 1'b1;
      tx_data_q <= pwdata_i[7:0];
      tx_ninth_q <= control_q[CT_TX8]; // RQ15
    end else if (tx_load) begin
      tx_pending_q <= 1'b0;
    end
  end
  wire tx_load_ok = tx_load && (control_q[CT_TRANSMITTER_ENABLE] || tx_state_q != TX_IDLE); // RQ14
  wire tx_accept = data_wr && (control_q[CT_TRANSMITTER_ENABLE] || tx_state_q != TX_IDLE); // RQ14

  // Receiver
  typedef enum {RX_IDLE, RX_START, RX_BITS} rx_state_e;
  rx_state_e rx_state_q;
  logic [3:0] rx_smp_q;
  logic [1:0] rx_votes_q;
  logic [3:0] rx_bit_q;
  logic [9:0] rx_shift_q;
  wire rx_vote_pt = rx_smp_q == VOTE_A || rx_smp_q == VOTE_B || rx_smp_q == VOTE_C;
  wire rx_vote_one = rx_votes_q[1]; // RQ19
  wire rx_end = tick16 && rx_smp_q == OVERSAMPLE_LAST;
  wire [3:0] rx_bits_total = control_q[CT_NINE] ? 4'h9 : 4'h8;
  wire rx_finish = rx_state_q == RX_BITS && rx_end && rx_bit_q == rx_bits_total;
  wire [9:0] rx_frame = {rx_vote_one, rx_shift_q[9:1]};
  wire rx_stop = rx_vote_one;
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !control_q[CT_RECEIVER_ENABLE]) begin
      rx_state_q <= RX_IDLE;
      rx_smp_q <= 4'h0;
      rx_votes_q <= 2'b00;
      rx_bit_q <= 4'h0;
      rx_shift_q <= 10'h000;
    end else if (tick16) begin
      if (rx_vote_pt && rxd_q && rx_votes_q != 2'b11) begin
        rx_votes_q <= rx_votes_q + 2'b01;
      end
      rx_smp_q <= rx_smp_q + 4'h1;
      unique case (rx_state_q)
        RX_IDLE: begin
          rx_smp_q <= 4'h1;
          rx_votes_q <= 2'b00;
          if (!rxd_q) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: if (rx_end) begin
          rx_votes_q <= 2'b00;
          rx_bit_q <= 4'h0;
          rx_state_q <= rx_vote_one ? RX_IDLE : RX_BITS; // RQ19
        end
        RX_BITS: if (rx_end) begin
          rx_votes_q <= 2'b00;
          rx_shift_q <= {rx_vote_one, rx_shift_q[9:1]};
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_finish) begin
            rx_state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end
  // Stop sample is the last vote; data sits in the upper frame bits
  wire [8:0] rx_word = control_q[CT_NINE] ? rx_frame[8:0] : {1'b0, rx_frame[8:1]};

  // Receive path: data, flags. Overrun held back until the older byte is read.
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      rx_data_q <= 8'h00;
      rxc_q <= 1'b0;
      fe_q <= 1'b0;
      ovr_q <= 1'b0;
      ovr_pend_q <= 1'b0;
      fe_pend_q <= 1'b0;
    end else if (rx_finish && !rxc_q) begin
      rx_data_q <= rx_word[7:0];
      rxc_q <= 1'b1; // RQ1
      fe_q <= ~rx_stop; // RQ8 RQ13
      ovr_q <= 1'b0; // RQ10
    end else if (rx_finish) begin
      ovr_pend_q <= 1'b1; // RQ9
      fe_pend_q <= ~rx_stop;
      if (data_rd) begin
        rxc_q <= 1'b0;
      end
    end else if (data_rd) begin
      rxc_q <= 1'b0; // RQ2
      if (ovr_pend_q) begin
        ovr_q <= 1'b1; // RQ9
        ovr_pend_q <= 1'b0;
      end
    end
  end

  // Transmit flags; set beats software clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      empty_q <= STATUS_RST[ST_EMPTY]; // RQ6
    end else if (tx_load_ok) begin
      empty_q <= 1'b1; // RQ5
    end else if (tx_accept) begin
      empty_q <= 1'b0; // RQ5
    end
  end
  wire txc_clr = tx_vector_ack_i || (wr && hit(paddr_i, STATUS_IDX) && pwdata_i[ST_TXC]) ||
                 (wr && hit(paddr_i, IRQ_ACK_IDX) && pwdata_i[ST_TXC]);
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      txc_q <= 1'b0;
    end else if (tx_done && control_q[CT_RECEIVER_ENABLE]) begin
      txc_q <= 1'b1; // RQ3 RQ13
    end else if (txc_clr) begin
      txc_q <= 1'b0; // RQ4 RQ23
    end
  end

  // Control, divisor
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      control_q <= CONTROL_RST;
      divisor_q <= DIVISOR_RST;
    end else begin
      if (wr && hit(paddr_i, CONTROL_IDX)) begin
        control_q[7:2] <= pwdata_i[7:2];
        control_q[CT_TX8] <= pwdata_i[CT_TX8];
      end
      if (rx_finish && !rxc_q && control_q[CT_NINE]) begin
        control_q[CT_RX8] <= rx_word[8]; // RQ15 RQ16
      end
      if (wr && hit(paddr_i, DIVISOR_IDX)) begin
        divisor_q <= pwdata_i[7:0];
      end
    end
  end

  // APB answer: one access cycle, registered read data
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (hit(paddr_i, DATA_IDX)) rd_mux = rx_data_q; // RQ21
    if (hit(paddr_i, STATUS_IDX)) rd_mux = {rxc_q, txc_q, empty_q, fe_q, ovr_q, 3'b000}; // RQ11 RQ23
    if (hit(paddr_i, CONTROL_IDX)) rd_mux = {control_q[7:1], 1'b0}; // RQ16
    if (hit(paddr_i, DIVISOR_IDX)) rd_mux = divisor_q;
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !mapped;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? {24'h0, rd_mux} : 32'h0;
    end
  end

  // Interrupt request levels
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      irq_o <= '0;
    end else begin
      irq_o.rx_complete <= global_irq_en_i && control_q[CT_RXIE] && rxc_q; // RQ2 RQ22
      irq_o.tx_complete <= global_irq_en_i && control_q[CT_TXIE] && txc_q; // RQ12 RQ22
      irq_o.tx_empty <= global_irq_en_i && control_q[CT_EMIE] && empty_q; // RQ7 RQ22
    end
  end

  rx_flag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rx_finish && !rxc_q |=> rxc_q) else $error("receive flag not set"); // RQ1
  rx_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    data_rd && !rx_finish |=> !rxc_q) else $error("read did not clear"); // RQ2
  empty_rst_a: assert property (@(posedge clk_sys_i) srst_i |=> empty_q)
    else $error("empty flag low after reset"); // RQ6
  empty_wr_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    tx_accept && !tx_load_ok |=> !empty_q) else $error("write kept empty"); // RQ5
  status_low_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    pready_o && !$past(pwrite_i) && $past(hit(paddr_i, STATUS_IDX)) |-> prdata_o[2:0] == 3'b000)
    else $error("reserved bits set"); // RQ11
  txc_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !control_q[CT_RECEIVER_ENABLE] && !txc_q |=> !txc_q) else $error("flag set while off"); // RQ13
  irq_empty_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    global_irq_en_i && control_q[CT_EMIE] && empty_q |=> irq_o.tx_empty)
    else $error("empty request missing"); // RQ7
  irq_txc_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    global_irq_en_i && control_q[CT_TXIE] && $rose(txc_q) |-> ##1 irq_o.tx_complete)
    else $error("transmit request missing"); // RQ12
  txc_ack_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    tx_vector_ack_i && !tx_done |=> !txc_q) else $error("ack did not clear"); // RQ4
  start_bit_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    tx_state_q == TX_LOADED && baud_tick |=> !txd_o) else $error("start bit not zero"); // RQ20
  baud_div_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    tick16 && divisor_q == 8'h01 && !$changed(divisor_q) && !(wr && hit(paddr_i, DIVISOR_IDX))
    |=> !tick16 ##1 tick16)
    else $error("divider period wrong"); // RQ17

endmodule // serial_uart

// ==== dv/serial_peer.sv ====
// Remote serial peer: drives frames into the receive line, captures frames from the transmit line
`timescale 1ns/10ps
module serial_peer (
  input wire logic clk_sys_i, // System clock
  input wire logic txd_i, // Line from the transceiver
  output logic rxd_o // Line into the transceiver
);
  int bit_cyc = 16;
  logic nine = 1'b0;
  logic [8:0] got_q[$];
  logic [8:0] shf;

  initial rxd_o = 1'b1;

  // Start zero, data from bit 0 up, optional ninth bit, then the chosen stop level
  task automatic send(input logic [8:0] d, input logic stop);
    logic [10:0] f;
    int nb;
    nb = nine ? 11 : 10;
    f = nine ? {stop, d, 1'b0} : {1'b0, stop, d[7:0], 1'b0};
    for (int i = 0; i < nb; i++) begin
      rxd_o <= f[i];
      repeat (bit_cyc) @(posedge clk_sys_i);
    end
    // Line idles high between frames
    rxd_o <= 1'b1;
    repeat (bit_cyc) @(posedge clk_sys_i);
  endtask

  // Samples mid bit; a frame without a high stop level is dropped
  always begin
    @(negedge txd_i);
    repeat (bit_cyc / 2) @(posedge clk_sys_i);
    shf = '0;
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (bit_cyc) @(posedge clk_sys_i);
      shf[i] = txd_i;
    end
    repeat (bit_cyc) @(posedge clk_sys_i);
    if (txd_i === 1'b1) got_q.push_back(shf);
  end
endmodule // serial_peer

// ==== dv/uart_status_control_baud_bench.sv ====
// Self-checking bench for the serial transceiver registers and lines
`timescale 1ns/10ps
module uart_status_control_baud_bench;
  import serial_pkg::*;
  logic clk_sys_i, srst_i, psel_i, penable_i, pwrite_i, tx_vector_ack_i, global_irq_en_i;
  logic [31:0] paddr_i, pwdata_i, prdata_o, r;
  logic pready_o, pslverr_o, txd_o, rxd_i, err;
  irq_s irq_o;
  int mismatches = 0;
  int samples_checked = 0;

  serial_uart DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .global_irq_en_i(global_irq_en_i), .tx_vector_ack_i(tx_vector_ack_i),
    .irq_o(irq_o), .rxd_i(rxd_i), .txd_o(txd_o));
  serial_peer peer (.clk_sys_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= {22'h0, idx, 2'b00};
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    r = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (pready_o !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask

  task automatic wait_st(input int b);
    int n;
    for (n = 0; n < 600; n++) begin
      apb(1'b0, STATUS_IDX, 32'h0);
      if (r[b] === 1'b1) break;
    end
    if (n == 600) begin
      mismatches++;
      test_done();
    end
  endtask

  task automatic irq_chk(input logic [2:0] exp);
    repeat (2) @(posedge clk_sys_i);
    chk({29'h0, irq_o}, {29'h0, exp});
  endtask

  initial begin
    srst_i = 1'b1;
    psel_i = 1'b0;
    penable_i = 1'b0;
    pwrite_i = 1'b0;
    paddr_i = '0;
    pwdata_i = '0;
    global_irq_en_i = 1'b0;
    tx_vector_ack_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'h20);
    apb(1'b0, CONTROL_IDX, 32'h0); chk(r, 32'h02);
    apb(1'b0, DIVISOR_IDX, 32'h0); chk(r, 32'h0);
    apb(1'b0, 8'h07, 32'h0); chk({31'h0, err}, 32'h1);
    apb(1'b1, STATUS_IDX, 32'hff);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'h20);
    apb(1'b1, CONTROL_IDX, 32'hff);
    apb(1'b0, CONTROL_IDX, 32'h0); chk(r, 32'hfe);
    irq_chk(3'b000);
    global_irq_en_i <= 1'b1;
    irq_chk(3'b001);
    apb(1'b1, CONTROL_IDX, 32'h18);
    irq_chk(3'b000);
    $display("test registers done");
    // Divisor 1 and 0 both give exact rates here
    apb(1'b1, DIVISOR_IDX, 32'h01);
    apb(1'b0, DIVISOR_IDX, 32'h0); chk(r, 32'h01);
    peer.bit_cyc = 32;
    apb(1'b1, CONTROL_IDX, 32'h58);
    apb(1'b1, DATA_IDX, 32'ha5);
    apb(1'b1, DATA_IDX, 32'h3c);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'h00);
    apb(1'b1, CONTROL_IDX, 32'h50);
    wait_st(ST_TXC);
    chk(peer.got_q.size(), 2);
    chk({23'h0, peer.got_q.pop_front()}, 32'ha5);
    chk({23'h0, peer.got_q.pop_front()}, 32'h3c);
    chk(r, 32'h60);
    irq_chk(3'b010);
    apb(1'b1, STATUS_IDX, 32'h40);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'h20);
    apb(1'b1, CONTROL_IDX, 32'h58);
    apb(1'b1, DATA_IDX, 32'h01);
    wait_st(ST_TXC);
    chk({23'h0, peer.got_q.pop_front()}, 32'h01);
    @(posedge clk_sys_i);
    tx_vector_ack_i <= 1'b1;
    @(posedge clk_sys_i);
    tx_vector_ack_i <= 1'b0;
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'h20);
    $display("test transmit done");
    apb(1'b1, DIVISOR_IDX, 32'h00);
    peer.bit_cyc = 16;
    apb(1'b1, CONTROL_IDX, 32'h98);
    peer.send(9'h03c, 1'b1);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'ha0);
    irq_chk(3'b100);
    apb(1'b0, DATA_IDX, 32'h0); chk(r, 32'h3c);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'h20);
    peer.send(9'h055, 1'b0);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'hb0);
    apb(1'b0, DATA_IDX, 32'h0); chk(r, 32'h55);
    peer.send(9'h00f, 1'b1);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'ha0);
    apb(1'b0, DATA_IDX, 32'h0);
    peer.send(9'h011, 1'b1);
    peer.send(9'h022, 1'b1);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'ha0);
    apb(1'b0, DATA_IDX, 32'h0); chk(r, 32'h11);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'h28);
    peer.send(9'h033, 1'b1);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'ha0);
    apb(1'b0, DATA_IDX, 32'h0); chk(r, 32'h33);
    $display("test receive done");
    peer.send(9'h066, 1'b0);
    apb(1'b1, CONTROL_IDX, 32'h08);
    peer.send(9'h077, 1'b1);
    apb(1'b0, STATUS_IDX, 32'h0); chk(r, 32'hb0);
    apb(1'b1, CONTROL_IDX, 32'h98);
    apb(1'b0, DATA_IDX, 32'h0); chk(r, 32'h66);
    $display("test receiver off done");
    peer.nine = 1'b1;
    apb(1'b1, CONTROL_IDX, 32'h1d);
    apb(1'b1, DATA_IDX, 32'h5a);
    wait_st(ST_TXC);
    chk({23'h0, peer.got_q.pop_front()}, 32'h15a);
    peer.send(9'h1c3, 1'b1);
    apb(1'b0, CONTROL_IDX, 32'h0); chk(r, 32'h1e);
    apb(1'b0, DATA_IDX, 32'h0); chk(r, 32'hc3);
    peer.send(9'h0c3, 1'b1);
    apb(1'b0, CONTROL_IDX, 32'h0); chk(r, 32'h1c);
    $display("test nine bit done");
    test_done();
  end
endmodule // uart_status_control_baud_bench
